// ===== rtl/gpio_irq_pkg.sv
package gpio_irq_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_PORT0_IRQ_FLAGS = 8'h89;
	localparam logic [7:0] IDX_PORT1_IRQ_FLAGS = 8'h8a;
	localparam logic [7:0] IDX_PORT2_IRQ_FLAGS = 8'h8b;
	localparam logic [7:0] IDX_PORT_IRQ_CONTROL = 8'h8c;
	localparam logic [7:0] IDX_PORT1_IRQ_MASK = 8'h8d;
	localparam logic [7:0] IDX_PORT2_INPUT_MODE = 8'hf7;

	localparam int ADDR_W = 12;

	// Port widths
	localparam int PORT0_W = 8;
	localparam int PORT1_W = 8;
	localparam int PORT2_W = 5;

	// Port-2 input-mode register fields
	localparam int BIT_PORT2_PULL_DIR = 7;
	localparam int BIT_PORT1_PULL_DIR = 6;
	localparam int BIT_PORT0_PULL_DIR = 5;

	// Port interrupt control register fields
	localparam int BIT_OUTPUT_DRIVE_STRENGTH = 6;
	localparam int BIT_PORT2_GROUP_IRQ_ENABLE = 5;
	localparam int BIT_PORT0_UPPER_IRQ_ENABLE = 4;
	localparam int BIT_PORT0_LOWER_IRQ_ENABLE = 3;
	localparam int BIT_PORT2_EDGE_SELECT = 2;
	localparam int BIT_PORT1_EDGE_SELECT = 1;
	localparam int BIT_PORT0_EDGE_SELECT = 0;

	// Reset values and control write mask
	localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
	localparam logic [7:0] RST_PORT_IRQ_CONTROL = 8'h00;
	localparam logic [7:0] RST_PORT1_IRQ_MASK = 8'h00;
	localparam logic [7:0] RST_PORT2_INPUT_MODE = 8'h00;
	localparam logic [6:0] CONTROL_WR_MASK = 7'h7f;

	// Edge detector warm-up length in cycles
	localparam int PRIME_CYCLES = 3;

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
		byte_addr = {2'h0, idx, 2'h0};
	endfunction

endpackage

// ===== rtl/edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface edge_if #(parameter int W = 8);
	logic falling_sel;
	logic [W-1:0] hit;
	modport det (input falling_sel, output hit);
	modport user (output falling_sel, input hit);
endinterface
`default_nettype wire

// ===== rtl/pin_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect #(
	parameter int W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] pins,
	edge_if.det eif
);

	logic [W-1:0] sync1_r;
	logic [W-1:0] sync2_r;
	logic [W-1:0] prev_r;
	logic [gpio_irq_pkg::PRIME_CYCLES-1:0] prime_r;
	wire primed = prime_r[gpio_irq_pkg::PRIME_CYCLES-1];
	wire [W-1:0] rise = sync2_r & ~prev_r;
	wire [W-1:0] fall = prev_r & ~sync2_r;

	////////////////////////////////////////////////////////////////////
	// Two-flop synchroniser, then one more stage for the comparison
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r <= '0;
			prime_r <= '0;
		end
		else
		begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
			prime_r <= {prime_r[gpio_irq_pkg::PRIME_CYCLES-2:0], 1'b1};
		end
	end

	// No hits until both compared stages hold real pin samples
	assign eif.hit = primed ? (eif.falling_sel ? fall : rise) : '0;

	////////////////////////////////////////////////////////////////////
	property p_edge_rise;
		@(posedge pclk) disable iff (!presetn)
		(primed && !eif.falling_sel && sync2_r[0] && !prev_r[0]) |-> eif.hit[0];
	endproperty
	a_edge_rise: assert property (p_edge_rise) else $error("rising edge missed");

	property p_edge_fall;
		@(posedge pclk) disable iff (!presetn)
		(eif.falling_sel && eif.hit[0]) |-> ($past(sync1_r[0], 2) && !$past(sync1_r[0]));
	endproperty
	a_edge_fall: assert property (p_edge_fall) else $error("falling hit without fall");

endmodule // pin_edge_detect
`default_nettype wire

// ===== rtl/gpio_port_irq.sv
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_irq #(
	parameter int P0_W = gpio_irq_pkg::PORT0_W,
	parameter int P1_W = gpio_irq_pkg::PORT1_W,
	parameter int P2_W = gpio_irq_pkg::PORT2_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [gpio_irq_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [P0_W-1:0] port0_in,
	input wire logic [P1_W-1:0] port1_in,
	input wire logic [P2_W-1:0] port2_in,
	output logic port0_pull_dir,
	output logic port1_pull_dir,
	output logic port2_pull_dir,
	output logic [P2_W-1:0] port2_pin_input_tristate,
	output logic [P2_W-1:0] port2_pullup_en,
	output logic [P2_W-1:0] port2_pulldown_en,
	output logic output_drive_strength,
	output logic irq
);

	////////////////////////////////////////////////////////////////////
	// Registers
	logic [P0_W-1:0] port0_irq_flags_r;
	logic [P1_W-1:0] port1_irq_flags_r;
	logic [P2_W-1:0] port2_irq_flags_r;
	logic [6:0] port_irq_control_r;
	logic [P1_W-1:0] port1_irq_mask_r;
	logic [7:0] port2_input_mode_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic irq_r;
	logic [P2_W-1:0] port2_pullup_en_r;
	logic [P2_W-1:0] port2_pulldown_en_r;

	////////////////////////////////////////////////////////////////////
	// Edge detectors
	edge_if #(.W(P0_W)) e0 ();
	edge_if #(.W(P1_W)) e1 ();
	edge_if #(.W(P2_W)) e2 ();

	assign e0.falling_sel = port_irq_control_r[gpio_irq_pkg::BIT_PORT0_EDGE_SELECT];
	assign e1.falling_sel = port_irq_control_r[gpio_irq_pkg::BIT_PORT1_EDGE_SELECT];
	assign e2.falling_sel = port_irq_control_r[gpio_irq_pkg::BIT_PORT2_EDGE_SELECT];

	pin_edge_detect #(.W(P0_W)) u_det0 (
		.pclk(pclk),
		.presetn(presetn),
		.pins(port0_in),
		.eif(e0)
	);

	pin_edge_detect #(.W(P1_W)) u_det1 (
		.pclk(pclk),
		.presetn(presetn),
		.pins(port1_in),
		.eif(e1)
	);

	pin_edge_detect #(.W(P2_W)) u_det2 (
		.pclk(pclk),
		.presetn(presetn),
		.pins(port2_in),
		.eif(e2)
	);

	////////////////////////////////////////////////////////////////////
	// APB decode: one wait state, registers act on the completing edge
	wire access = psel && penable;
	wire sample = access && !pready_r;
	wire done = access && pready_r;
	wire wr_en = done && pwrite;

	wire sel_f0 = paddr == gpio_irq_pkg::byte_addr(gpio_irq_pkg::IDX_PORT0_IRQ_FLAGS);
	wire sel_f1 = paddr == gpio_irq_pkg::byte_addr(gpio_irq_pkg::IDX_PORT1_IRQ_FLAGS);
	wire sel_f2 = paddr == gpio_irq_pkg::byte_addr(gpio_irq_pkg::IDX_PORT2_IRQ_FLAGS);
	wire sel_ctl = paddr == gpio_irq_pkg::byte_addr(gpio_irq_pkg::IDX_PORT_IRQ_CONTROL);
	wire sel_msk = paddr == gpio_irq_pkg::byte_addr(gpio_irq_pkg::IDX_PORT1_IRQ_MASK);
	wire sel_mode = paddr == gpio_irq_pkg::byte_addr(gpio_irq_pkg::IDX_PORT2_INPUT_MODE);
	wire mapped = sel_f0 || sel_f1 || sel_f2 || sel_ctl || sel_msk || sel_mode;

	wire [31:0] rd_mux =
		sel_f0 ? {24'h00_0000, port0_irq_flags_r} :
		sel_f1 ? {24'h00_0000, port1_irq_flags_r} :
		sel_f2 ? {27'h000_0000, port2_irq_flags_r} :
		sel_ctl ? {25'h000_0000, port_irq_control_r} :
		sel_msk ? {24'h00_0000, port1_irq_mask_r} :
		sel_mode ? {24'h00_0000, port2_input_mode_r} :
		32'h0000_0000;

	////////////////////////////////////////////////////////////////////
	// Flag update: write-0 clears, a same-cycle edge wins over the clear
	wire [P0_W-1:0] clr0 = (wr_en && sel_f0) ? ~pwdata[P0_W-1:0] : '0;
	wire [P1_W-1:0] clr1 = (wr_en && sel_f1) ? ~pwdata[P1_W-1:0] : '0;
	wire [P2_W-1:0] clr2 = (wr_en && sel_f2) ? ~pwdata[P2_W-1:0] : '0;

	wire [P0_W-1:0] port0_irq_flags_nxt = (port0_irq_flags_r & ~clr0) | e0.hit;
	wire [P1_W-1:0] port1_irq_flags_nxt = (port1_irq_flags_r & ~clr1) | e1.hit;
	wire [P2_W-1:0] port2_irq_flags_nxt = (port2_irq_flags_r & ~clr2) | e2.hit;

	////////////////////////////////////////////////////////////////////
	// Interrupt gating
	wire en_p2 = port_irq_control_r[gpio_irq_pkg::BIT_PORT2_GROUP_IRQ_ENABLE];
	wire en_p0h = port_irq_control_r[gpio_irq_pkg::BIT_PORT0_UPPER_IRQ_ENABLE];
	wire en_p0l = port_irq_control_r[gpio_irq_pkg::BIT_PORT0_LOWER_IRQ_ENABLE];
	wire src_p2 = en_p2 && (|port2_irq_flags_r);
	wire src_p0h = en_p0h && (|port0_irq_flags_r[7:4]);
	wire src_p0l = en_p0l && (|port0_irq_flags_r[3:0]);
	wire src_p1 = |(port1_irq_flags_r & port1_irq_mask_r);
	wire irq_nxt = src_p2 || src_p0h || src_p0l || src_p1;

	////////////////////////////////////////////////////////////////////
	// Pad control for port 2 from mode and pull direction
	wire pull2 = port2_input_mode_r[gpio_irq_pkg::BIT_PORT2_PULL_DIR];
	wire [P2_W-1:0] pulled2 = ~port2_input_mode_r[P2_W-1:0];
	wire [P2_W-1:0] port2_pullup_en_nxt = pulled2 & {P2_W{!pull2}};
	wire [P2_W-1:0] port2_pulldown_en_nxt = pulled2 & {P2_W{pull2}};

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			pready_r <= sample;
			pslverr_r <= sample && !mapped;
			prdata_r <= (sample && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port0_irq_flags_r <= gpio_irq_pkg::RST_IRQ_FLAGS[P0_W-1:0];
			port1_irq_flags_r <= gpio_irq_pkg::RST_IRQ_FLAGS[P1_W-1:0];
			port2_irq_flags_r <= gpio_irq_pkg::RST_IRQ_FLAGS[P2_W-1:0];
		end
		else
		begin
			port0_irq_flags_r <= port0_irq_flags_nxt;
			port1_irq_flags_r <= port1_irq_flags_nxt;
			port2_irq_flags_r <= port2_irq_flags_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port_irq_control_r <= gpio_irq_pkg::RST_PORT_IRQ_CONTROL[6:0];
			port1_irq_mask_r <= gpio_irq_pkg::RST_PORT1_IRQ_MASK[P1_W-1:0];
			port2_input_mode_r <= gpio_irq_pkg::RST_PORT2_INPUT_MODE;
		end
		else if (wr_en)
		begin
			if (sel_ctl)
				port_irq_control_r <= pwdata[6:0] & gpio_irq_pkg::CONTROL_WR_MASK;
			if (sel_msk)
				port1_irq_mask_r <= pwdata[P1_W-1:0];
			if (sel_mode)
				port2_input_mode_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_r <= 1'b0;
			port2_pullup_en_r <= '0;
			port2_pulldown_en_r <= '0;
		end
		else
		begin
			irq_r <= irq_nxt;
			port2_pullup_en_r <= port2_pullup_en_nxt;
			port2_pulldown_en_r <= port2_pulldown_en_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;
	assign port0_pull_dir = port2_input_mode_r[gpio_irq_pkg::BIT_PORT0_PULL_DIR];
	assign port1_pull_dir = port2_input_mode_r[gpio_irq_pkg::BIT_PORT1_PULL_DIR];
	assign port2_pull_dir = port2_input_mode_r[gpio_irq_pkg::BIT_PORT2_PULL_DIR];
	assign port2_pin_input_tristate = port2_input_mode_r[P2_W-1:0];
	assign port2_pullup_en = port2_pullup_en_r;
	assign port2_pulldown_en = port2_pulldown_en_r;
	assign output_drive_strength = port_irq_control_r[gpio_irq_pkg::BIT_OUTPUT_DRIVE_STRENGTH];

	////////////////////////////////////////////////////////////////////
	// Checks
	property p_f0_set;
		@(posedge pclk) disable iff (!presetn)
		(e0.hit != '0) |=> ((port0_irq_flags_r & $past(e0.hit)) == $past(e0.hit));
	endproperty
	a_f0_set: assert property (p_f0_set) else $error("port0 flag not set");

	property p_f1_set;
		@(posedge pclk) disable iff (!presetn)
		(e1.hit != '0) |=> ((port1_irq_flags_r & $past(e1.hit)) == $past(e1.hit));
	endproperty
	a_f1_set: assert property (p_f1_set) else $error("port1 flag not set");

	property p_f2_read;
		@(posedge pclk) disable iff (!presetn)
		(sample && !pwrite && sel_f2) |=> (prdata_r[7:5] == 3'h0 && prdata_r[4:0] == $past(port2_irq_flags_r));
	endproperty
	a_f2_read: assert property (p_f2_read) else $error("port2 flag read wrong");

	property p_f0_clear;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && sel_f0 && e0.hit == '0) |=> (port0_irq_flags_r == ($past(port0_irq_flags_r) & $past(pwdata[7:0])));
	endproperty
	a_f0_clear: assert property (p_f0_clear) else $error("write-0 clear wrong");

	property p_irq_p2;
		@(posedge pclk) disable iff (!presetn)
		(en_p2 && port2_irq_flags_r != '0) |=> irq_r;
	endproperty
	a_irq_p2: assert property (p_irq_p2) else $error("port2 irq missing");

	property p_irq_p0h;
		@(posedge pclk) disable iff (!presetn)
		(en_p0h && port0_irq_flags_r[7:4] != 4'h0) |=> irq_r;
	endproperty
	a_irq_p0h: assert property (p_irq_p0h) else $error("port0 upper irq missing");

	property p_irq_p0l;
		@(posedge pclk) disable iff (!presetn)
		(en_p0l && port0_irq_flags_r[3:0] != 4'h0) |=> irq_r;
	endproperty
	a_irq_p0l: assert property (p_irq_p0l) else $error("port0 lower irq missing");

	property p_irq_idle;
		@(posedge pclk) disable iff (!presetn)
		(!src_p2 && !src_p0h && !src_p0l && (port1_irq_flags_r & port1_irq_mask_r) == '0) |=> !irq_r;
	endproperty
	a_irq_idle: assert property (p_irq_idle) else $error("irq without masked source");

	property p_mode_wr;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && sel_mode) |=> (port2_pin_input_tristate == $past(pwdata[4:0]) && port2_pull_dir == $past(pwdata[7]));
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("input mode write lost");

	property p_pull_pad;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && sel_mode && pwdata[7] && pwdata[0] == 1'b0) |=> ##1 (port2_pulldown_en[0] && !port2_pullup_en[0]);
	endproperty
	a_pull_pad: assert property (p_pull_pad) else $error("pull-down not applied");

	property p_drive_wr;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && sel_ctl) |=> (output_drive_strength == $past(pwdata[6]) && port_irq_control_r[2:0] == $past(pwdata[2:0]));
	endproperty
	a_drive_wr: assert property (p_drive_wr) else $error("control write lost");

	property p_pol0;
		@(posedge pclk) disable iff (!presetn)
		e0.hit[0] |-> ($past(port0_in[0], 2) != port_irq_control_r[gpio_irq_pkg::BIT_PORT0_EDGE_SELECT]
			&& $past(port0_in[0], 3) == port_irq_control_r[gpio_irq_pkg::BIT_PORT0_EDGE_SELECT]);
	endproperty
	a_pol0: assert property (p_pol0) else $error("port0 polarity mismatch");

	property p_pol1;
		@(posedge pclk) disable iff (!presetn)
		e1.hit[0] |-> ($past(port1_in[0], 2) != port_irq_control_r[gpio_irq_pkg::BIT_PORT1_EDGE_SELECT]
			&& $past(port1_in[0], 3) == port_irq_control_r[gpio_irq_pkg::BIT_PORT1_EDGE_SELECT]);
	endproperty
	a_pol1: assert property (p_pol1) else $error("port1 polarity mismatch");

	property p_pol2;
		@(posedge pclk) disable iff (!presetn)
		e2.hit[0] |-> ($past(port2_in[0], 2) != port_irq_control_r[gpio_irq_pkg::BIT_PORT2_EDGE_SELECT]
			&& $past(port2_in[0], 3) == port_irq_control_r[gpio_irq_pkg::BIT_PORT2_EDGE_SELECT]);
	endproperty
	a_pol2: assert property (p_pol2) else $error("port2 polarity mismatch");

	property p_f2_set;
		@(posedge pclk) disable iff (!presetn)
		(e2.hit != '0) |=> ((port2_irq_flags_r & $past(e2.hit)) == $past(e2.hit));
	endproperty
	a_f2_set: assert property (p_f2_set) else $error("port2 flag not set");

	property p_f1_clear;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && sel_f1) |=> (port1_irq_flags_r ==
			(($past(port1_irq_flags_r) & $past(pwdata[P1_W-1:0])) | $past(e1.hit)));
	endproperty
	a_f1_clear: assert property (p_f1_clear) else $error("port1 clear or set-wins wrong");

	property p_f2_clear;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && sel_f2) |=> (port2_irq_flags_r ==
			(($past(port2_irq_flags_r) & $past(pwdata[P2_W-1:0])) | $past(e2.hit)));
	endproperty
	a_f2_clear: assert property (p_f2_clear) else $error("port2 clear or set-wins wrong");

	property p_irq_p1;
		@(posedge pclk) disable iff (!presetn)
		((port1_irq_flags_r & port1_irq_mask_r) != '0) |=> irq_r;
	endproperty
	a_irq_p1: assert property (p_irq_p1) else $error("port1 irq missing");

	property p_pullup_pad;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && sel_mode && !pwdata[7] && !pwdata[0]) |=> ##1 (port2_pullup_en[0] && !port2_pulldown_en[0]);
	endproperty
	a_pullup_pad: assert property (p_pullup_pad) else $error("pull-up not applied");

	property p_tristate_pad;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && sel_mode && pwdata[0]) |=> ##1 (!port2_pullup_en[0] && !port2_pulldown_en[0]);
	endproperty
	a_tristate_pad: assert property (p_tristate_pad) else $error("tristate pin still pulled");

endmodule // gpio_port_irq
`default_nettype wire

// ===== tb/pin_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// External circuitry on the three ports; changes pins only after a clock edge
module pin_model (
	input wire logic pclk,
	output logic [7:0] port0_in,
	output logic [7:0] port1_in,
	output logic [4:0] port2_in
);
	initial
	begin
		port0_in = 8'h00;
		port1_in = 8'h00;
		port2_in = 5'h00;
	end

	task automatic drive(input int p, input logic [7:0] v);
		@(posedge pclk);
		case (p)
			0: port0_in <= v;
			1: port1_in <= v;
			default: port2_in <= v[4:0];
		endcase
	endtask
endmodule // pin_model
`default_nettype wire

// ===== tb/gpio_port_irq_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) \
		begin \
			n_errors++; \
			$display("MISMATCH %0t got %h exp %h", $time, got, exp); \
		end \
	end
////////////////////////////////////////////////////////////////////////////////
module gpio_port_irq_tb;
	localparam logic [7:0] F0 = gpio_irq_pkg::IDX_PORT0_IRQ_FLAGS;
	localparam logic [7:0] CTL = gpio_irq_pkg::IDX_PORT_IRQ_CONTROL;
	localparam logic [7:0] MSK = gpio_irq_pkg::IDX_PORT1_IRQ_MASK;
	localparam logic [7:0] MODE = gpio_irq_pkg::IDX_PORT2_INPUT_MODE;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, last_err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [7:0] port0_in, port1_in;
	logic [4:0] port2_in, port2_pin_input_tristate, port2_pullup_en, port2_pulldown_en;
	logic port0_pull_dir, port1_pull_dir, port2_pull_dir, output_drive_strength;
	int n_errors, n_checks, cycles;

	gpio_port_irq gpio_port_irq_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .port0_in(port0_in),
		.port1_in(port1_in), .port2_in(port2_in), .port0_pull_dir(port0_pull_dir),
		.port1_pull_dir(port1_pull_dir), .port2_pull_dir(port2_pull_dir),
		.port2_pin_input_tristate(port2_pin_input_tristate),
		.port2_pullup_en(port2_pullup_en), .port2_pulldown_en(port2_pulldown_en),
		.output_drive_strength(output_drive_strength), .irq(irq));
	pin_model pin_model_i (.pclk(pclk), .port0_in(port0_in), .port1_in(port1_in),
		.port2_in(port2_in));

	always #20 pclk = ~pclk;

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] rd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'hff_ff00, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		apb(1'b1, idx, v, rdv);
	endtask

	task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00, rdv);
		`CHK(rdv, {24'h00_0000, exp})
	endtask

	task automatic t_reset();
		chk_reg(F0, 8'h00);
		chk_reg(F0 + 8'h01, 8'h00);
		chk_reg(F0 + 8'h02, 8'h00);
		chk_reg(MSK, 8'h00);
		chk_reg(MODE, 8'h00);
		chk_reg(CTL, 8'h00);
		`CHK(port2_pin_input_tristate, 5'h00)
		`CHK(port2_pullup_en, 5'h1f)
	endtask

	task automatic t_mode();
		wr(MODE, 8'he3);
		chk_reg(MODE, 8'he3);
		`CHK({port2_pull_dir, port1_pull_dir, port0_pull_dir}, 3'b111)
		`CHK(port2_pin_input_tristate, 5'h03)
		`CHK({port2_pulldown_en, port2_pullup_en}, 10'h380)
		wr(MODE, 8'h40);
		chk_reg(MODE, 8'h40);
		`CHK({port2_pull_dir, port1_pull_dir, port0_pull_dir}, 3'b010)
		`CHK({port2_pulldown_en, port2_pullup_en}, 10'h01f)
	endtask

	task automatic t_regs();
		wr(CTL, 8'hff);
		chk_reg(CTL, 8'h7f);
		`CHK(output_drive_strength, 1'b1)
		wr(CTL, 8'h00);
		@(posedge pclk);
		`CHK(output_drive_strength, 1'b0)
		wr(MSK, 8'h5a);
		chk_reg(MSK, 8'h5a);
		wr(MSK, 8'h00);
		wr(F0 + 8'h02, 8'hff);
		chk_reg(F0 + 8'h02, 8'h00);
		`CHK(last_err, 1'b0)
		apb(1'b1, 8'h90, 8'hff, rdv);
		`CHK(last_err, 1'b1)
		apb(1'b0, 8'h90, 8'h00, rdv);
		`CHK({last_err, rdv}, {1'b1, 32'h0000_0000})
	endtask

	// Edges of the chosen polarity set flags, the other polarity is ignored
	task automatic t_edge(input int p, input logic pol);
		logic [7:0] fi;
		logic [7:0] m;
		logic [7:0] base;
		fi = F0 + 8'(p);
		m = (p == 2) ? 8'h1f : 8'hff;
		base = pol ? 8'hff : 8'h00;
		wr(CTL, {7'h00, pol} << p);
		pin_model_i.drive(p, base);
		repeat (8) @(posedge pclk);
		wr(fi, 8'h00);
		pin_model_i.drive(p, base ^ 8'ha5);
		repeat (8) @(posedge pclk);
		chk_reg(fi, 8'ha5 & m);
		pin_model_i.drive(p, base);
		repeat (8) @(posedge pclk);
		chk_reg(fi, 8'ha5 & m);
		wr(fi, 8'hfe);
		chk_reg(fi, 8'ha4 & m);
		wr(fi, 8'h00);
		chk_reg(fi, 8'h00);
	endtask

	// Flag is raised with enables off, then irq follows only the right enable
	task automatic t_irq(input int p, input logic [7:0] v, input logic [7:0] idx,
		input logic [7:0] good, input logic [7:0] bad);
		wr(CTL, 8'h00);
		wr(MSK, 8'h00);
		for (int i = 0; i < 3; i++)
			pin_model_i.drive(i, 8'h00);
		repeat (8) @(posedge pclk);
		for (int i = 0; i < 3; i++)
			wr(F0 + 8'(i), 8'h00);
		pin_model_i.drive(p, v);
		repeat (8) @(posedge pclk);
		`CHK(irq, 1'b0)
		wr(idx, bad);
		repeat (3) @(posedge pclk);
		`CHK(irq, 1'b0)
		wr(idx, good);
		repeat (3) @(posedge pclk);
		`CHK(irq, 1'b1)
		wr(F0 + 8'(p), 8'h00);
		repeat (3) @(posedge pclk);
		`CHK(irq, 1'b0)
	endtask

	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		n_errors = 0;
		n_checks = 0;
		cycles = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		t_reset();
		t_mode();
		t_regs();
		t_edge(0, 1'b0);
		t_edge(0, 1'b1);
		t_edge(1, 1'b0);
		t_edge(1, 1'b1);
		t_edge(2, 1'b0);
		t_edge(2, 1'b1);
		t_irq(0, 8'h80, CTL, 8'h10, 8'h08);
		t_irq(0, 8'h01, CTL, 8'h08, 8'h10);
		t_irq(1, 8'h04, MSK, 8'h04, 8'hfb);
		t_irq(2, 8'h10, CTL, 8'h20, 8'h18);
		results();
	end
endmodule // gpio_port_irq_tb
`default_nettype wire
